// >>> hw/discrete_io_pkg.sv
// Constants, register map and carrier types for the discrete I/O block.
// Assumes a 100 MHz pclk and an APB master on the register side.
// Functional notes
// - Debounced change reaches equations after settle plus at most one pass.
// - Change validated after a pass starts waits for the next pass.
// - Raw contact inputs are sampled every half millisecond.
// - Events carry microsecond time of the first sample showing new state.
// - Rising and falling edges use the same debounce and settle interval.
// - Thirty-two soft inputs, each operand zero until a signal arrives.
// - Soft input state survives control power loss.
// - Disabled soft input holds operand zero and ignores changes.
// - Pulse mode: operand high for exactly one pass per rising edge.
// - Latched mode: operand follows most recent received value.
// - Contact output driven by operate, held while seal-in is selected and trip current flows.
// - Output state changes log events when logging is enabled, one event per cycle: a fault, then an input, then the lowest output wins.
// - Series current detector sets trip current present and absent flags.
// - Latching positions are read at power-up before evaluation starts.
// - Commanded versus read-back mismatch raises latching fault and event.
// - Close command sealed until closed; then close chatter is ignored.
// - Open command sealed until open; then open chatter is ignored.
// - Both requests: close if close priority, else open.
// - New input accepted only after stable for whole settle interval.
// - Debounced operand updates at start of next evaluation pass.
// - Evaluation pass runs eight times per power-system cycle.
package discrete_io_pkg;
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned SAMPLE_NS = 500_000;
   localparam int unsigned SAMPLE_CYC = SAMPLE_NS / 10;
   localparam int unsigned US_CYC = CLK_HZ / 1_000_000;
   localparam int unsigned PASSES_PER_CYCLE = 8;
   localparam int unsigned COIL_TIMEOUT_MS = 50;
   localparam int unsigned COIL_TIMEOUT_SAMPLES = COIL_TIMEOUT_MS * 2;
   localparam logic [7:0] SETTLE_RESET = 8'h05;
   localparam logic [31:0] PASS_RESET = 32'h0003_28B8;

   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_INPUTS = 8'h04;
   localparam logic [7:0] A_SETTLE = 8'h08;
   localparam logic [7:0] A_PASS = 8'h0C;
   localparam logic [7:0] A_SOFT_EN = 8'h10;
   localparam logic [7:0] A_SOFT_LATCH = 8'h14;
   localparam logic [7:0] A_SOFT_CMD = 8'h18;
   localparam logic [7:0] A_SOFT_OUT = 8'h1C;
   localparam logic [7:0] A_OUT_CFG = 8'h20;
   localparam logic [7:0] A_EVT_DATA = 8'h24;
   localparam logic [7:0] A_EVT_TIME = 8'h28;
   localparam logic [7:0] A_EVT_POP = 8'h2C;
   localparam logic [7:0] A_TIME = 8'h30;

   typedef enum logic [1:0] {
      ST_READBACK = 2'b00,
      ST_RUN = 2'b01
   } boot_state_t;

   typedef enum logic [1:0] {
      EV_INPUT = 2'b00,
      EV_OUTPUT = 2'b01,
      EV_LATCH_FAULT = 2'b10
   } event_kind_t;

   typedef struct packed {
      logic valid;
      event_kind_t kind;
      logic [4:0] index;
      logic level;
      logic [31:0] stamp_us;
   } event_t;

   typedef struct packed {
      logic close_coil;
      logic open_coil;
      logic fault;
   } latch_drive_t;
endpackage

// >>> hw/discrete_io_control.sv
// Discrete I/O: contact input debounce, soft inputs, contact and latching
// outputs, behind an APB slave. Field pins are asynchronous to pclk.
`timescale 1ns/1ps
module discrete_io_control #(
   parameter int unsigned N_IN = 8,
   parameter int unsigned N_OUT = 4,
   parameter int unsigned N_SOFT = 32,
   parameter int unsigned SAMPLE_CYCLES = discrete_io_pkg::SAMPLE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N_IN-1:0] contact_in,
   input wire logic [N_OUT-1:0] operate_in,
   input wire logic [N_OUT-1:0] seal_sel_in,
   input wire logic [N_OUT-1:0] trip_current_sense,
   input wire logic close_request,
   input wire logic open_request,
   input wire logic latch_position,
   output logic [N_OUT-1:0] contact_out,
   output logic [N_OUT-1:0] trip_current_present,
   output logic [N_OUT-1:0] trip_current_absent,
   output logic close_coil,
   output logic open_coil,
   output logic latch_fault,
   output logic [N_IN-1:0] input_operand,
   output logic [N_SOFT-1:0] soft_operand,
   output logic pass_strobe,
   output logic eval_enable
);
   import discrete_io_pkg::*;

   // Synchronisers for contact, trip current and position pins
   logic [N_IN-1:0] cin_m_q, cin_s_q;
   logic [N_OUT-1:0] ic_m_q, ic_s_q;
   logic lp_m_q, lp_s_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cin_m_q <= '0;
         cin_s_q <= '0;
         ic_m_q <= '0;
         ic_s_q <= '0;
         lp_m_q <= 1'b0;
         lp_s_q <= 1'b0;
      end else begin
         cin_m_q <= contact_in;
         cin_s_q <= cin_m_q;
         ic_m_q <= trip_current_sense;
         ic_s_q <= ic_m_q;
         lp_m_q <= latch_position;
         lp_s_q <= lp_m_q;
      end
   end

   // Configuration registers
   logic [7:0] settle_q;
   logic [31:0] pass_period_q;
   logic [N_SOFT-1:0] soft_en_q, soft_latch_q, soft_cmd_q;
   logic [N_OUT-1:0] out_evt_en_q;
   logic in_evt_en_q, close_prio_q;
   logic wr, rd_pop;
   assign wr = psel && penable && pwrite;
   assign rd_pop = psel && penable && !pwrite && paddr == A_EVT_POP;

   // Soft input command register is intended to sit in retained power
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_q <= SETTLE_RESET;
         pass_period_q <= PASS_RESET;
         soft_en_q <= '0;
         soft_latch_q <= '0;
         out_evt_en_q <= '0;
         in_evt_en_q <= 1'b0;
         close_prio_q <= 1'b1;
      end else if (wr) begin
         case (paddr)
            A_SETTLE: settle_q <= pwdata[7:0];
            A_PASS: pass_period_q <= pwdata;
            A_SOFT_EN: soft_en_q <= pwdata[N_SOFT-1:0];
            A_SOFT_LATCH: soft_latch_q <= pwdata[N_SOFT-1:0];
            A_OUT_CFG: begin
               out_evt_en_q <= pwdata[N_OUT-1:0];
               in_evt_en_q <= pwdata[8];
               close_prio_q <= pwdata[9];
            end
            default: ;
         endcase
      end
   end

   // No reset: the command word must survive a control power cycle,
   // operands stay zero meanwhile because the enables do reset
   always_ff @(posedge pclk) begin
      if (wr && paddr == A_SOFT_CMD) begin
         soft_cmd_q <= pwdata[N_SOFT-1:0];
      end
   end

   // Sample tick, microsecond clock, evaluation pass
   logic [15:0] smp_cnt_q;
   logic [7:0] us_cnt_q;
   logic [31:0] time_us_q, pass_cnt_q;
   logic tick;
   logic pass_go;
   assign tick = smp_cnt_q == 16'(SAMPLE_CYCLES - 1);
   assign pass_go = pass_cnt_q >= pass_period_q - 32'h0000_0001;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp_cnt_q <= '0;
         us_cnt_q <= '0;
         time_us_q <= '0;
      end else begin
         smp_cnt_q <= tick ? '0 : smp_cnt_q + 16'h0001;
         if (us_cnt_q == 8'(US_CYC - 1)) begin
            us_cnt_q <= '0;
            time_us_q <= time_us_q + 32'h0000_0001;
         end else begin
            us_cnt_q <= us_cnt_q + 8'h01;
         end
      end
   end

   boot_state_t boot_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pass_cnt_q <= '0;
         pass_strobe <= 1'b0;
      end else begin
         // Period set by software from frequency tracking: cycle/8
         pass_strobe <= boot_q == ST_RUN && pass_go;
         pass_cnt_q <= pass_go ? '0 : pass_cnt_q + 32'h0000_0001;
      end
   end

   // Debounce: one stable counter per input, symmetric for both edges
   logic [N_IN-1:0] valid_q, validated_q;
   logic [7:0] stab_q [N_IN];
   logic [31:0] first_us_q [N_IN];
   logic [N_IN-1:0] in_evt_req;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_q <= '0;
         for (int i = 0; i < N_IN; i++) begin
            stab_q[i] <= '0;
            first_us_q[i] <= '0;
         end
      end else if (tick) begin
         for (int i = 0; i < N_IN; i++) begin
            if (cin_s_q[i] == valid_q[i]) begin
               stab_q[i] <= '0;
            end else begin
               if (stab_q[i] == 8'h00) begin
                  first_us_q[i] <= time_us_q;
               end
               if (stab_q[i] + 8'h01 >= settle_q) begin
                  valid_q[i] <= cin_s_q[i];
                  stab_q[i] <= '0;
               end else begin
                  stab_q[i] <= stab_q[i] + 8'h01;
               end
            end
         end
      end
   end
   assign in_evt_req = valid_q ^ validated_q;

   // Operands move only at a pass start, so a late change waits one pass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         validated_q <= '0;
         input_operand <= '0;
      end else begin
         validated_q <= valid_q;
         if (pass_go && boot_q == ST_RUN) begin
            input_operand <= valid_q;
         end
      end
   end

   // Soft inputs
   logic [N_SOFT-1:0] soft_prev_q, soft_pend_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_prev_q <= '0;
         soft_pend_q <= '0;
         soft_operand <= '0;
      end else begin
         soft_prev_q <= soft_cmd_q;
         soft_pend_q <= (soft_pend_q | (soft_cmd_q & ~soft_prev_q))
                        & soft_en_q;
         if (pass_go && boot_q == ST_RUN) begin
            soft_operand <= soft_en_q &
               ((soft_latch_q & soft_cmd_q) |
                (~soft_latch_q & (soft_pend_q |
                 (soft_cmd_q & ~soft_prev_q))));
            soft_pend_q <= '0;
         end
      end
   end

   // Contact outputs with seal-in and current monitor
   logic [N_OUT-1:0] out_chg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         contact_out <= '0;
         trip_current_present <= '0;
         trip_current_absent <= '0;
      end else begin
         trip_current_present <= ic_s_q;
         trip_current_absent <= ~ic_s_q;
         if (boot_q == ST_RUN) begin
            contact_out <= operate_in |
                           (contact_out & seal_sel_in & ic_s_q);
         end
      end
   end
   assign out_chg = (operate_in | (contact_out & seal_sel_in & ic_s_q))
                    ^ contact_out;

   // Latching output: boot readback, sealed coils, discrepancy
   logic cmd_pos_q;
   logic [7:0] coil_t_q;
   logic want_close, want_open, fault_evt;
   always_comb begin
      want_close = close_request && (!open_request || close_prio_q);
      want_open = open_request && (!close_request || !close_prio_q);
   end
   assign fault_evt = tick && (close_coil || open_coil) &&
                      coil_t_q == 8'(COIL_TIMEOUT_SAMPLES - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_q <= ST_READBACK;
         cmd_pos_q <= 1'b0;
         close_coil <= 1'b0;
         open_coil <= 1'b0;
         latch_fault <= 1'b0;
         coil_t_q <= '0;
         eval_enable <= 1'b0;
      end else begin
         case (boot_q)
            ST_READBACK: if (tick) begin
               cmd_pos_q <= lp_s_q;
               boot_q <= ST_RUN;
               eval_enable <= 1'b1;
            end
            ST_RUN: begin
               if (want_close && !cmd_pos_q) begin
                  cmd_pos_q <= 1'b1;
                  close_coil <= 1'b1;
                  open_coil <= 1'b0;
                  coil_t_q <= '0;
               end else if (want_open && cmd_pos_q) begin
                  cmd_pos_q <= 1'b0;
                  open_coil <= 1'b1;
                  close_coil <= 1'b0;
                  coil_t_q <= '0;
               end else if ((close_coil || open_coil) && lp_s_q == cmd_pos_q) begin
                  close_coil <= 1'b0;
                  open_coil <= 1'b0;
               end else if (tick && (close_coil || open_coil)) begin
                  coil_t_q <= coil_t_q + 8'h01;
               end
               if (fault_evt) begin
                  close_coil <= 1'b0;
                  open_coil <= 1'b0;
               end
               if (fault_evt || (!close_coil && !open_coil &&
                                 lp_s_q != cmd_pos_q)) begin
                  latch_fault <= 1'b1;
               end else if (lp_s_q == cmd_pos_q) begin
                  latch_fault <= 1'b0;
               end
            end
            default: boot_q <= ST_READBACK;
         endcase
      end
   end

   // Event register: newest event held until popped, overflow sticky
   event_t evt_q;
   logic evt_ovf_q, fault_prev_q;
   event_t evt_d;
   always_comb begin
      evt_d = '0;
      for (int i = N_OUT - 1; i >= 0; i--) begin
         if (out_chg[i] && out_evt_en_q[i] && boot_q == ST_RUN) begin
            evt_d = '{1'b1, EV_OUTPUT, 5'(i), ~contact_out[i], time_us_q};
         end
      end
      for (int i = N_IN - 1; i >= 0; i--) begin
         if (in_evt_req[i] && in_evt_en_q) begin
            evt_d = '{1'b1, EV_INPUT, 5'(i), valid_q[i], first_us_q[i]};
         end
      end
      if (latch_fault && !fault_prev_q) begin
         evt_d = '{1'b1, EV_LATCH_FAULT, 5'h00, 1'b1, time_us_q};
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_q <= '0;
         evt_ovf_q <= 1'b0;
         fault_prev_q <= 1'b0;
      end else begin
         fault_prev_q <= latch_fault;
         if (evt_d.valid) begin
            evt_q <= evt_d;
            evt_ovf_q <= evt_ovf_q | (evt_q.valid && !rd_pop);
         end else if (rd_pop) begin
            evt_q.valid <= 1'b0;
            evt_ovf_q <= 1'b0;
         end
      end
   end

   // APB: zero wait states, unmapped addresses answer with pslverr
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= '0;
         if (psel && !penable) begin
            case (paddr)
               A_STATUS: prdata <= {26'h0, evt_ovf_q, evt_q.valid,
                                    latch_fault, cmd_pos_q, lp_s_q,
                                    boot_q == ST_RUN};
               A_INPUTS: prdata <= 32'(valid_q);
               A_SETTLE: prdata <= {24'h0, settle_q};
               A_PASS: prdata <= pass_period_q;
               A_SOFT_EN: prdata <= 32'(soft_en_q);
               A_SOFT_LATCH: prdata <= 32'(soft_latch_q);
               A_SOFT_CMD: prdata <= 32'(soft_cmd_q);
               A_SOFT_OUT: prdata <= 32'(soft_operand);
               A_OUT_CFG: prdata <= {22'h0, close_prio_q, in_evt_en_q,
                                     8'(out_evt_en_q)};
               A_EVT_DATA: prdata <= {evt_q.valid, 21'h0, evt_q.kind,
                                      evt_q.index, evt_q.level, 2'b00};
               A_EVT_TIME: prdata <= evt_q.stamp_us;
               A_EVT_POP: prdata <= 32'(evt_q.valid);
               A_TIME: prdata <= time_us_q;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule

// >>> dv/discrete_io_assertions.sv
// Port-level checks for the discrete I/O block.
// Assumes a bind onto discrete_io_control, single pclk domain.
`timescale 1ns/1ps
module discrete_io_assertions #(
   parameter int unsigned N_IN = 8,
   parameter int unsigned N_OUT = 4,
   parameter int unsigned N_SOFT = 32
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [N_OUT-1:0] operate_in,
   input wire logic [N_OUT-1:0] contact_out,
   input wire logic [N_OUT-1:0] trip_current_present,
   input wire logic [N_OUT-1:0] trip_current_absent,
   input wire logic close_coil,
   input wire logic open_coil,
   input wire logic latch_position,
   input wire logic latch_fault,
   input wire logic [N_IN-1:0] input_operand,
   input wire logic [N_SOFT-1:0] soft_operand,
   input wire logic pass_strobe,
   input wire logic eval_enable
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_no_wait: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error flag outside access");
   a_pass_single: assert property (pass_strobe |=> !pass_strobe)
      else $error("pass strobe longer than a cycle");
   a_boot_first: assert property (!eval_enable |-> !pass_strobe)
      else $error("pass before position readback");
   a_input_on_pass: assert property ($changed(input_operand) |->
      pass_strobe || $past(pass_strobe))
      else $error("input operand moved between passes");
   a_soft_on_pass: assert property ($changed(soft_operand) |->
      pass_strobe || $past(pass_strobe))
      else $error("soft operand moved between passes");
   a_flags_inverse: assert property (eval_enable |->
      trip_current_absent == ~trip_current_present)
      else $error("current flags not complementary");
   a_operate_drives: assert property (eval_enable &&
      $rose(operate_in[0]) |-> ##[0:400] contact_out[0])
      else $error("operate did not energise output");
   a_close_ends_closed: assert property ($fell(close_coil) |->
      ##[0:2] (latch_position || latch_fault))
      else $error("close coil released while open");
   a_open_ends_open: assert property ($fell(open_coil) |->
      ##[0:2] (!latch_position || latch_fault))
      else $error("open coil released while closed");
   a_coils_apart: assert property (!(close_coil && open_coil))
      else $error("both coils driven");
endmodule

// >>> dv/field_model.sv
// Far side: bistable contact mechanism and trip circuit current.
// Assumes coil drives are pclk-synchronous levels.
`timescale 1ns/1ps
module field_model #(
   parameter int unsigned MOVE_CYC = 300
) (
   input wire logic pclk,
   input wire logic close_coil,
   input wire logic open_coil,
   input wire logic [3:0] contact_out,
   input wire logic stuck,
   input wire logic circuit_open,
   output logic latch_position,
   output logic [3:0] trip_current_sense
);
   int unsigned dwell = 0;
   initial latch_position = 1'b0;
   // Slower than a pass, so only the seal keeps the coil up to the end
   always @(posedge pclk) begin
      if ((close_coil || open_coil) && !stuck) begin
         dwell <= dwell + 1;
      end else begin
         dwell <= 0;
      end
      if (dwell == MOVE_CYC) begin
         latch_position <= close_coil;
      end
   end
   assign trip_current_sense = contact_out & {4{!circuit_open}};
endmodule

// >>> dv/testbench.sv
// Self-checking bench: APB registers, debounce, soft inputs, outputs.
// Assumes field_model and the checker, bound below.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
   error_cnt++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
`define WAITC(c, lim) begin n = 0; while (!(c) && n < lim) begin \
   @(posedge pclk); n++; end if (n >= lim) begin error_cnt++; \
   tally_and_finish; end end
module testbench;
   import discrete_io_pkg::*;
   localparam int SC = 50;
   localparam int PP = 200;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, contact_in = 8'h00, input_operand;
   logic [31:0] pwdata = 32'h0000_0000, prdata, soft_operand, v;
   logic pready, pslverr, close_request = 0, open_request = 0;
   logic latch_position, close_coil, open_coil, latch_fault;
   logic pass_strobe, eval_enable, stuck = 0, circuit_open = 0;
   logic [3:0] operate_in = 4'h0, seal_sel_in = 4'h0, sense;
   logic [3:0] contact_out, tc_present, tc_absent;
   logic [32:0] exp_q[$];
   logic [32:0] e_m;
   logic [7:0] prev;
   int error_cnt = 0, samples_checked = 0, n, hc, ho;
   integer seed = 32'hd79f_ed75;
   initial forever #5 pclk = ~pclk;
   discrete_io_control #(.SAMPLE_CYCLES(SC)) i_discrete_io_control (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .contact_in(contact_in),
      .operate_in(operate_in), .seal_sel_in(seal_sel_in),
      .trip_current_sense(sense), .close_request(close_request),
      .open_request(open_request), .latch_position(latch_position),
      .contact_out(contact_out), .trip_current_present(tc_present),
      .trip_current_absent(tc_absent), .close_coil(close_coil),
      .open_coil(open_coil), .latch_fault(latch_fault),
      .input_operand(input_operand), .soft_operand(soft_operand),
      .pass_strobe(pass_strobe), .eval_enable(eval_enable));
   field_model i_field_model (.pclk(pclk), .close_coil(close_coil),
      .open_coil(open_coil), .contact_out(contact_out), .stuck(stuck),
      .circuit_open(circuit_open), .latch_position(latch_position),
      .trip_current_sense(sense));
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // Reads queue their expectation; the monitor below compares
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, input logic [32:0] e);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      `WAITC(pready === 1'b1, 20)
      psel <= 0;
      penable <= 0;
   endtask
   task automatic watch(input int c);
      hc = 0;
      ho = 0;
      repeat (c) begin
         @(posedge pclk);
         hc += close_coil;
         ho += open_coil;
      end
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         e_m = exp_q.pop_front();
         if (e_m[32]) `CHK(pslverr, 1'b1)
         else `CHK({pslverr, prdata}, e_m)
      end
   end
   initial begin
      tick(2);
      presetn <= 1;
      tick(2);
      `CHK(eval_enable, 1'b0)
      `WAITC(eval_enable === 1'b1, 200)
      apb(0, A_SETTLE, '0, {25'h000_0000, SETTLE_RESET});
      apb(0, A_PASS, '0, {1'b0, PASS_RESET});
      apb(0, A_OUT_CFG, '0, 33'h0_0000_0200);
      apb(0, 8'h40, '0, 33'h1_0000_0000);
      apb(1, A_PASS, PP, '0);
      apb(1, A_SETTLE, 3, '0);
      $display("test registers done");
      repeat (4) begin
         v = $random(seed);
         @(posedge pclk);
         prev = input_operand;
         contact_in <= v[7:0];
         tick(SC);
         `CHK(input_operand, prev)
         tick(12 * SC);
         `CHK(input_operand, v[7:0])
         contact_in <= ~v[7:0];
         tick(SC / 2);
         contact_in <= v[7:0];
         tick(12 * SC);
         `CHK(input_operand, v[7:0])
      end
      $display("test debounce done");
      v = $random(seed);
      apb(1, A_SOFT_EN, 32'h0000_FFFF, '0);
      apb(1, A_SOFT_LATCH, 32'h0000_00FF, '0);
      apb(1, A_SOFT_CMD, v, '0);
      tick(3 * PP);
      `CHK(soft_operand, {24'h00_0000, v[7:0]})
      apb(1, A_SOFT_CMD, 32'h0000_0000, '0);
      tick(3 * PP);
      apb(1, A_SOFT_CMD, 32'h0000_0100, '0);
      n = 0;
      repeat (4 * PP) begin
         @(posedge pclk);
         n += soft_operand[8];
      end
      `CHK(n >= PP - 1 && n <= PP + 1, 1'b1)
      $display("test soft inputs done");
      seal_sel_in <= 4'h1;
      operate_in <= 4'h3;
      tick(2 * PP);
      `CHK({contact_out[1:0], tc_present[1:0]}, 4'hF)
      operate_in <= 4'h0;
      tick(2 * PP);
      `CHK(contact_out[1:0], 2'b01)
      circuit_open <= 1;
      tick(2 * PP);
      `CHK({contact_out[0], tc_absent[0]}, 2'b01)
      circuit_open <= 0;
      $display("test contact outputs done");
      close_request <= 1;
      tick(PP + 20);
      close_request <= 0;
      `CHK(close_coil, 1'b1)
      `WAITC(latch_position === 1'b1, 1000)
      tick(PP);
      `CHK({close_coil, latch_fault}, 2'b00)
      repeat (4) begin
         close_request <= ~close_request;
         watch(PP);
         `CHK(hc, 0)
      end
      close_request <= 1;
      open_request <= 1;
      watch(3 * PP);
      `CHK({ho, latch_position}, {32'd0, 1'b1})
      apb(1, A_OUT_CFG, 32'h0000_0000, '0);
      `WAITC(latch_position === 1'b0, 1500)
      close_request <= 0;
      watch(2 * PP);
      `CHK({hc, open_coil}, {32'd0, 1'b0})
      open_request <= 0;
      stuck <= 1;
      close_request <= 1;
      `WAITC(latch_fault === 1'b1, 7000)
      `CHK(latch_fault, 1'b1)
      close_request <= 0;
      stuck <= 0;
      apb(0, A_STATUS, '0, 33'h0_0000_001D);
      $display("test latching done");
      presetn <= 0;
      tick(2);
      presetn <= 1;
      tick(2);
      `CHK(eval_enable, 1'b0)
      `WAITC(eval_enable === 1'b1, 200)
      apb(0, A_SOFT_CMD, '0, 33'h0_0000_0100);
      $display("test restart done");
      tally_and_finish;
   end
endmodule
bind discrete_io_control discrete_io_assertions #(.N_IN(N_IN),
   .N_OUT(N_OUT), .N_SOFT(N_SOFT)) i_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .operate_in(operate_in), .contact_out(contact_out),
   .trip_current_present(trip_current_present),
   .trip_current_absent(trip_current_absent), .close_coil(close_coil),
   .open_coil(open_coil), .latch_position(latch_position),
   .latch_fault(latch_fault), .input_operand(input_operand),
   .soft_operand(soft_operand), .pass_strobe(pass_strobe),
   .eval_enable(eval_enable));
